// >>> rtl/timer16_counter_input_capture.sv
// 16-bit timer/counter with input capture, Avalon-MM register slave
// assumes synchronous pins and an Avalon master that honours waitrequest
//
// The register addresses and the Avalon-MM register port were decided locally.
`default_nettype none

module timer16_counter_input_capture #(
	parameter int PRESC_BITS = timer16_pkg::PRESC_W
) (
	input  wire logic        ref_clk,           // system clock, 100 MHz
	input  wire logic        reset_n,           // async reset, active low
	input  wire logic [5:0]  avs_address,       // byte address
	input  wire logic        avs_read,          // read request
	input  wire logic        avs_write,         // write request
	input  wire logic [31:0] avs_writedata,     // write data, low byte used
	input  wire logic [3:0]  avs_byteenable,    // lane 0 enables write
	output logic [31:0]      avs_readdata,      // read data, registered
	output logic             avs_waitrequest,   // stall until answered
	input  wire logic        external_count_pin, // external tick source
	input  wire logic        capture_pin,        // capture trigger pin
	input  wire logic        comparator_output,  // comparator capture source
	input  wire logic        capture_irq_ack,    // capture irq serviced
	input  wire logic        overflow_irq_ack,   // overflow irq serviced
	output logic             capture_irq,        // capture request
	output logic             overflow_irq        // overflow request
);
	import timer16_pkg::*;

	initial begin
		if (PRESC_BITS < 10)
			$error("PRESC_BITS must cover divide by 1024");
	end

	typedef struct packed {
		logic [7:0]            temp;
		logic [15:0]           cnt;
		logic [15:0]           icr;
		logic [7:0]            ctrl_a;
		logic [7:0]            ctrl_b;
		logic                  cmp_sel;
		logic                  cap_ie;
		logic                  ovf_ie;
		logic                  ovf_flag;
		logic                  cap_flag;
		logic                  dir_down;
		logic [PRESC_BITS-1:0] presc;
		logic [1:0]            ext_hist;
		logic                  pend;
		logic [7:0]            rdata;
	} state_s;

	state_s      state_r;
	state_s      state_nxt;
	logic [3:0]  mode;
	logic [2:0]  clk_sel;
	logic [15:0] top;
	logic        dual_slope;
	logic        ovf_at_top;
	logic        icr_top;
	logic        tick;
	logic        cap_src;
	logic        cap_evt;
	logic        ovf_set;
	logic        rd_first;
	logic        wr_acc;
	logic        wr_cnt_lo;
	logic        wr_icr_lo;
	logic [7:0]  wdata;

	// mode field spread over both controls
	assign mode    = {state_r.ctrl_b[WGM_HI_LSB +: 2], state_r.ctrl_a[WGM_LO_LSB +: 2]};
	assign clk_sel = state_r.ctrl_b[CS_LSB +: 3];
	assign wdata   = avs_writedata[7:0];

	always_comb begin
		unique case (mode)
			4'h1, 4'h5:               top = TOP_8BIT;
			4'h2, 4'h6:               top = TOP_9BIT;
			4'h3, 4'h7:               top = TOP_10BIT;
			4'h8, 4'hA, 4'hC, 4'hE:   top = state_r.icr;
			default:                  top = CNT_MAX;
		endcase
	end

	assign dual_slope = (mode == 4'h1) || (mode == 4'h2) || (mode == 4'h3) ||
	                    (mode == 4'h8) || (mode == 4'hA);
	assign ovf_at_top = (mode == 4'h5) || (mode == 4'h6) || (mode == 4'h7) ||
	                    (mode == 4'hE);
	assign icr_top    = (mode == 4'h8) || (mode == 4'hA) || (mode == 4'hC) ||
	                    (mode == 4'hE);

	always_comb begin
		unique case (clk_sel)
			CS_STOP:     tick = 1'b0;
			CS_DIV1:     tick = 1'b1;
			CS_DIV8:     tick = &state_r.presc[2:0];
			CS_DIV64:    tick = &state_r.presc[5:0];
			CS_DIV256:   tick = &state_r.presc[7:0];
			CS_DIV1024:  tick = &state_r.presc[9:0];
			CS_EXT_FALL: tick = state_r.ext_hist[1] & ~state_r.ext_hist[0];
			CS_EXT_RISE: tick = ~state_r.ext_hist[1] & state_r.ext_hist[0];
		endcase
	end

	assign cap_src = state_r.cmp_sel ? comparator_output : capture_pin;

	// filtered edge, disarmed in top modes
	capture_filter u_filter (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.raw_in     (cap_src),
		.filter_en  (state_r.ctrl_b[FILTER_BIT]),
		.rising_sel (state_r.ctrl_b[EDGE_BIT]),
		.enable     (~icr_top),
		.edge_out   (cap_evt)
	);

	// bus slave: one wait cycle, answer on the second
	assign avs_waitrequest = (avs_read | avs_write) & ~state_r.pend;
	assign avs_readdata    = {24'h00_0000, state_r.rdata};
	assign rd_first        = avs_read & ~state_r.pend;
	assign wr_acc          = avs_write & state_r.pend & avs_byteenable[0];
	assign wr_cnt_lo       = wr_acc && (avs_address == ADDR_CNT_LO);
	assign wr_icr_lo       = wr_acc && (avs_address == ADDR_CAP_LO) && icr_top;

	assign ovf_set = tick && !wr_cnt_lo &&
	                 (dual_slope ? (state_r.dir_down && state_r.cnt == CNT_BOTTOM)
	                             : (ovf_at_top ? (state_r.cnt == top)
	                                           : (state_r.cnt == CNT_MAX)));

	always_comb begin
		state_nxt          = state_r;
		state_nxt.presc    = state_r.presc + 1'b1;
		state_nxt.ext_hist = {state_r.ext_hist[0], external_count_pin};
		state_nxt.pend     = (avs_read | avs_write) & ~state_r.pend;

		if (tick) begin
			if (dual_slope) begin
				if (!state_r.dir_down) begin
					if (state_r.cnt >= top) begin
						state_nxt.dir_down = 1'b1;
						state_nxt.cnt      = state_r.cnt - 1'b1;
					end else begin
						state_nxt.cnt = state_r.cnt + 1'b1;
					end
				end else if (state_r.cnt == CNT_BOTTOM) begin
					state_nxt.dir_down = 1'b0;
					state_nxt.cnt      = state_r.cnt + 1'b1;
				end else begin
					state_nxt.cnt = state_r.cnt - 1'b1;
				end
			end else if (state_r.cnt == top) begin
				state_nxt.cnt      = CNT_BOTTOM;
				state_nxt.dir_down = 1'b0;
			end else begin
				state_nxt.cnt      = state_r.cnt + 1'b1;
				state_nxt.dir_down = 1'b0;
			end
		end

		if (cap_evt)
			state_nxt.icr = state_r.cnt;

		// read answer and low-byte latch at first cycle
		if (rd_first) begin
			unique case (avs_address)
				ADDR_CTRL_A:   state_nxt.rdata = state_r.ctrl_a;
				ADDR_CTRL_B:   state_nxt.rdata = state_r.ctrl_b;
				ADDR_CNT_LO: begin
					state_nxt.rdata = state_r.cnt[7:0];
					state_nxt.temp  = state_r.cnt[15:8];
				end
				ADDR_CAP_LO: begin
					state_nxt.rdata = state_r.icr[7:0];
					state_nxt.temp  = state_r.icr[15:8];
				end
				ADDR_CNT_HI, ADDR_CAP_HI: state_nxt.rdata = state_r.temp;
				ADDR_FLAGS: begin
					state_nxt.rdata          = 8'h00;
					state_nxt.rdata[OVF_BIT] = state_r.ovf_flag;
					state_nxt.rdata[CAP_BIT] = state_r.cap_flag;
				end
				ADDR_IRQ_EN: begin
					state_nxt.rdata          = 8'h00;
					state_nxt.rdata[OVF_BIT] = state_r.ovf_ie;
					state_nxt.rdata[CAP_BIT] = state_r.cap_ie;
				end
				ADDR_CMP_CTRL: begin
					state_nxt.rdata              = 8'h00;
					state_nxt.rdata[CMP_SEL_BIT] = state_r.cmp_sel;
				end
				default:       state_nxt.rdata = 8'h00;
			endcase
		end

		// flag clears first so that a same-cycle set wins below
		if (wr_acc && avs_address == ADDR_FLAGS) begin
			if (wdata[OVF_BIT])
				state_nxt.ovf_flag = 1'b0;
			if (wdata[CAP_BIT])
				state_nxt.cap_flag = 1'b0;
		end
		if (capture_irq_ack)
			state_nxt.cap_flag = 1'b0;
		if (overflow_irq_ack)
			state_nxt.ovf_flag = 1'b0;

		if (wr_acc) begin
			unique case (avs_address)
				ADDR_CTRL_A:   state_nxt.ctrl_a = wdata;
				ADDR_CTRL_B:   state_nxt.ctrl_b = wdata;
				ADDR_CNT_HI, ADDR_CAP_HI: state_nxt.temp = wdata;
				ADDR_IRQ_EN: begin
					state_nxt.ovf_ie = wdata[OVF_BIT];
					state_nxt.cap_ie = wdata[CAP_BIT];
				end
				ADDR_CMP_CTRL: state_nxt.cmp_sel = wdata[CMP_SEL_BIT];
				default:       state_nxt.temp = state_r.temp;
			endcase
		end

		if (wr_cnt_lo)
			state_nxt.cnt = {state_r.temp, wdata};
		// capture write only in top modes
		if (wr_icr_lo)
			state_nxt.icr = {state_r.temp, wdata};

		if (ovf_set)
			state_nxt.ovf_flag = 1'b1;
		if (cap_evt)
			state_nxt.cap_flag = 1'b1;
	end

	assign capture_irq  = state_r.cap_flag & state_r.cap_ie;
	assign overflow_irq = state_r.ovf_flag & state_r.ovf_ie;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r        <= '0;
			state_r.cnt    <= WORD_RESET;
			state_r.icr    <= WORD_RESET;
			state_r.ctrl_a <= CTRL_RESET;
			state_r.ctrl_b <= CTRL_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	sequence s_cnt_write;
		wr_cnt_lo;
	endsequence

	sequence s_cnt_low_read;
		rd_first && avs_address == ADDR_CNT_LO;
	endsequence

	sequence s_hi_write;
		wr_acc && (avs_address == ADDR_CNT_HI || avs_address == ADDR_CAP_HI);
	endsequence

	chk_stop_holds: assert property (
		(clk_sel == CS_STOP && !wr_cnt_lo) |=> state_r.cnt == $past(state_r.cnt))
		else $error("counter moved while stopped");

	chk_write_priority: assert property (
		s_cnt_write |=> state_r.cnt == {$past(state_r.temp), $past(wdata)})
		else $error("counter write lost to counting");

	chk_normal_step: assert property (
		(mode == 4'h0 && tick && !wr_cnt_lo) |=> state_r.cnt == $past(state_r.cnt) + 16'h0001)
		else $error("normal mode did not count up by one");

	chk_cap_copy: assert property (
		cap_evt |=> (state_r.icr == $past(state_r.cnt)) && state_r.cap_flag)
		else $error("capture did not copy counter and set flag");

	chk_cap_request: assert property (
		(cap_evt && state_r.cap_ie && !wr_acc) |=> capture_irq)
		else $error("capture request missing");

	chk_cap_ack_clear: assert property (
		(capture_irq_ack && !cap_evt) |=> !state_r.cap_flag)
		else $error("serviced capture flag stayed set");

	chk_lowread_latch: assert property (
		(rd_first && avs_address == ADDR_CAP_LO) |=>
		state_r.temp == $past(state_r.icr[15:8]) ##1 1'b1)
		else $error("capture high byte not latched");

	chk_icr_locked: assert property (
		(!icr_top && !cap_evt) |=> state_r.icr == $past(state_r.icr))
		else $error("capture register changed without capture");

	chk_top_no_capture: assert property (
		icr_top |-> !cap_evt)
		else $error("capture fired in a top mode");

	chk_read_answer: assert property (
		rd_first |=> !avs_waitrequest)
		else $error("read not answered after one wait cycle");

	chk_cnt_latch: assert property (
		s_cnt_low_read |=> state_r.temp == $past(state_r.cnt[15:8]))
		else $error("counter high byte not latched");

	chk_latch_write: assert property (
		s_hi_write |=> state_r.temp == $past(wdata))
		else $error("high byte write missed the shared latch");

	chk_ovf_flag_set: assert property (
		ovf_set |=> state_r.ovf_flag)
		else $error("overflow flag not set");

	chk_ovf_request: assert property (
		(ovf_set && state_r.ovf_ie && !wr_acc) |=> overflow_irq)
		else $error("overflow request missing");

	chk_ovf_ack_clear: assert property (
		(overflow_irq_ack && !ovf_set) |=> !state_r.ovf_flag)
		else $error("serviced overflow flag stayed set");

	chk_w1c_clear: assert property (
		(wr_acc && avs_address == ADDR_FLAGS && wdata[CAP_BIT] && !cap_evt) |=>
		!state_r.cap_flag)
		else $error("write one did not clear capture flag");

	chk_dual_turn: assert property (
		(tick && dual_slope && !state_r.dir_down && state_r.cnt >= top && !wr_cnt_lo) |=>
		state_r.dir_down)
		else $error("dual slope did not turn at top");

	chk_top_clear: assert property (
		(tick && !dual_slope && state_r.cnt == top && !wr_cnt_lo) |=> state_r.cnt == CNT_BOTTOM)
		else $error("single slope did not clear at top");

	chk_icr_write: assert property (
		wr_icr_lo |=> state_r.icr == {$past(state_r.temp), $past(wdata)})
		else $error("capture register write lost");

endmodule : timer16_counter_input_capture

`default_nettype wire

// >>> rtl/timer16_pkg.sv
// constants for the 16-bit timer/counter with input capture
// assumes an Avalon-MM slave with 32-bit data, one byte register per word
//
// Overview of operation
// - clock select field picks tick; zero stops
// - sixteen-bit counter counts up, down or clears
// - low-byte access moves high byte through latch
// - bus write beats clear or count
// - counter reachable from bus without tick
// - waveform mode field sets counting sequence
// - overflow flag set per mode, raises request
// - selected edge copies counter into capture register
// - capture flag set in copy cycle
// - enabled flag requests irq; ack or one clears
// - capture low read latches high for later
// - capture register writable only in top modes
// - capture pin default, comparator when selected
// - changing source may capture; software clears flag
// - same sampling as count pin; filter adds four
// - capture input disabled when register sets top
// - pin level from port can trigger capture
// - filter output changes after four equal samples
// - filter enabled by control bit, system clock
// - each capture overwrites the capture register
// - one high-byte latch shared by counter and capture registers
`default_nettype none

package timer16_pkg;

	// register byte addresses
	localparam logic [5:0] ADDR_CTRL_A   = 6'h00;
	localparam logic [5:0] ADDR_CTRL_B   = 6'h04;
	localparam logic [5:0] ADDR_CNT_LO   = 6'h08;
	localparam logic [5:0] ADDR_CNT_HI   = 6'h0C;
	localparam logic [5:0] ADDR_CAP_LO   = 6'h10;
	localparam logic [5:0] ADDR_CAP_HI   = 6'h14;
	localparam logic [5:0] ADDR_FLAGS    = 6'h18;
	localparam logic [5:0] ADDR_IRQ_EN   = 6'h1C;
	localparam logic [5:0] ADDR_CMP_CTRL = 6'h20;

	// field positions
	localparam int CS_LSB      = 0;
	localparam int WGM_LO_LSB  = 0;
	localparam int WGM_HI_LSB  = 3;
	localparam int EDGE_BIT    = 6;
	localparam int FILTER_BIT  = 7;
	localparam int OVF_BIT     = 0;
	localparam int CAP_BIT     = 5;
	localparam int CMP_SEL_BIT = 2;

	// reset values
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	localparam logic [15:0] WORD_RESET  = 16'h0000;

	// counter landmarks
	localparam logic [15:0] CNT_MAX     = 16'hFFFF;
	localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
	localparam logic [15:0] TOP_8BIT    = 16'h00FF;
	localparam logic [15:0] TOP_9BIT    = 16'h01FF;
	localparam logic [15:0] TOP_10BIT   = 16'h03FF;

	// clock select codes
	localparam logic [2:0] CS_STOP     = 3'h0;
	localparam logic [2:0] CS_DIV1     = 3'h1;
	localparam logic [2:0] CS_DIV8     = 3'h2;
	localparam logic [2:0] CS_DIV64    = 3'h3;
	localparam logic [2:0] CS_DIV256   = 3'h4;
	localparam logic [2:0] CS_DIV1024  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRESC_W = 10;

	// noise filter length in system clocks
	localparam int FILTER_LEN = 4;

endpackage : timer16_pkg

`default_nettype wire

// >>> rtl/capture_filter.sv
// noise filter and edge detector for one capture source
// assumes raw_in is synchronous to ref_clk
`default_nettype none

module capture_filter #(
	parameter int FILTER_LEN = timer16_pkg::FILTER_LEN
) (
	input  wire logic ref_clk,     // system clock
	input  wire logic reset_n,     // async reset, active low
	input  wire logic raw_in,      // selected capture source
	input  wire logic filter_en,   // noise filter on
	input  wire logic rising_sel,  // 1 rising, 0 falling
	input  wire logic enable,      // detector armed
	output logic      edge_out     // one-cycle capture strobe
);
	import timer16_pkg::*;

	initial begin
		if (FILTER_LEN < 2)
			$error("FILTER_LEN must be at least 2");
	end

	typedef struct packed {
		logic                  sample;
		logic [FILTER_LEN-1:0] hist;
		logic                  filt;
		logic                  prev;
	} filt_s;

	filt_s st_r;
	filt_s st_nxt;
	logic  level;

	assign level = filter_en ? st_r.filt : st_r.sample;

	always_comb begin
		st_nxt        = st_r;
		st_nxt.sample = raw_in;
		st_nxt.hist   = {st_r.hist[FILTER_LEN-2:0], st_r.sample};
		if (&st_nxt.hist || ~|st_nxt.hist)
			st_nxt.filt = st_nxt.hist[0];
		st_nxt.prev = level;
	end

	assign edge_out = enable & (rising_sel ? (level & ~st_r.prev) : (~level & st_r.prev));

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	chk_filter_agree: assert property (
		(filter_en && $changed(st_r.filt)) |->
		((&st_r.hist || ~|st_r.hist) && st_r.filt == st_r.hist[0]))
		else $error("filter output changed without agreeing samples");

endmodule : capture_filter

`default_nettype wire

// >>> tb/cpu_bus_model.sv
// cpu side of the timer: byte transfers on the avalon-mm register port
// assumes the bench calls its tasks right after a rising ref_clk edge
`default_nettype none

module cpu_bus_model (
	input  wire logic        ref_clk,         // system clock
	output logic [5:0]       avs_address,     // byte address
	output logic             avs_read,        // read request
	output logic             avs_write,       // write request
	output logic [31:0]      avs_writedata,   // write data
	output logic [3:0]       avs_byteenable,  // lane enables
	input  wire logic [31:0] avs_readdata,    // read data
	input  wire logic        avs_waitrequest  // stall
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		avs_address = 6'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h1;
	end

	// one access, held until waitrequest is seen low at a rising edge
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= w;
		avs_read <= !w;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask : acc

	task automatic wr16(input logic [5:0] lo, input logic [15:0] v);
		logic [7:0] q;
		acc(1'b1, lo + 6'h04, v[15:8], q);
		acc(1'b1, lo, v[7:0], q);
	endtask : wr16

	task automatic rd16(input logic [5:0] lo, output logic [15:0] v);
		acc(1'b0, lo, 8'h00, v[7:0]);
		acc(1'b0, lo + 6'h04, 8'h00, v[15:8]);
	endtask : rd16
endmodule : cpu_bus_model

`default_nettype wire

// >>> tb/timer16_counter_input_capture_bench.sv
// self-checking bench for the 16-bit timer with input capture
// assumes cpu_bus_model as register master; pins driven at rising edges
`default_nettype none

module timer16_counter_input_capture_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import timer16_pkg::*;

	`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
		$display("BAD %s exp %h got %h", n, e, g); end end

	logic ref_clk, reset_n, ext_pin, cap_pin, cmp_out, cap_ack, ovf_ack;
	logic [5:0] addr;
	logic rd_r, wr_r, waitreq, cap_irq, ovf_irq;
	logic [31:0] wdata, rdata;
	logic [3:0] be;
	int miscompares, compares, cycles;

	cpu_bus_model cpu (.ref_clk(ref_clk), .avs_address(addr), .avs_read(rd_r),
		.avs_write(wr_r), .avs_writedata(wdata), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(waitreq));

	timer16_counter_input_capture dut (.ref_clk(ref_clk), .reset_n(reset_n),
		.avs_address(addr), .avs_read(rd_r), .avs_write(wr_r),
		.avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(waitreq), .external_count_pin(ext_pin),
		.capture_pin(cap_pin), .comparator_output(cmp_out),
		.capture_irq_ack(cap_ack), .overflow_irq_ack(ovf_ack),
		.capture_irq(cap_irq), .overflow_irq(ovf_irq));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic stop_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		cpu.acc(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [5:0] a, output logic [7:0] q);
		cpu.acc(1'b0, a, 8'h00, q);
	endtask : rd

	task automatic pins(input logic c, input logic m, input logic e, input int n);
		cap_pin <= c;
		cmp_out <= m;
		ext_pin <= e;
		repeat (n) @(posedge ref_clk);
	endtask : pins

	task automatic t_reset_map();
		logic [7:0] q;
		rd(ADDR_CTRL_B, q); `CHK("ctrl_b", CTRL_RESET, q)
		rd(ADDR_FLAGS, q); `CHK("flags", 8'h00, q)
		rd(6'h3C, q); `CHK("unmapped", 8'h00, q)
	endtask : t_reset_map

	task automatic t_latch();
		logic [15:0] v;
		cpu.wr16(ADDR_CNT_LO, 16'h1234);
		repeat (20) @(posedge ref_clk);
		cpu.rd16(ADDR_CNT_LO, v); `CHK("cnt stopped", 16'h1234, v)
		wr(ADDR_CNT_LO, 8'h56);
		cpu.rd16(ADDR_CNT_LO, v); `CHK("latch reuse", 16'h1256, v)
		cpu.wr16(ADDR_CAP_LO, 16'h0777);
		cpu.rd16(ADDR_CAP_LO, v); `CHK("cap write mode0", 16'h0000, v)
	endtask : t_latch

	task automatic t_count();
		logic [15:0] v;
		logic [7:0] q;
		wr(ADDR_IRQ_EN, 8'h21);
		cpu.wr16(ADDR_CNT_LO, 16'hFFF0);
		wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
		cpu.wr16(ADDR_CNT_LO, 16'hFFE0);
		repeat (40) @(posedge ref_clk);
		wr(ADDR_CTRL_B, {5'h00, CS_STOP});
		cpu.rd16(ADDR_CNT_LO, v); `CHK("wrap up", 16'h000B, v)
		`CHK("ovf irq", 1'b1, ovf_irq)
		ovf_ack <= 1'b1;
		@(posedge ref_clk);
		ovf_ack <= 1'b0;
		repeat (2) @(posedge ref_clk);
		`CHK("ovf ack", 1'b0, ovf_irq)
		cpu.wr16(ADDR_CNT_LO, 16'h0000);
		wr(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
		repeat (3) begin
			pins(1'b0, 1'b0, 1'b1, 4);
			pins(1'b0, 1'b0, 1'b0, 4);
		end
		wr(ADDR_CTRL_B, {5'h00, CS_STOP});
		rd(ADDR_CNT_LO, q); `CHK("ext ticks", 8'h03, q)
		wr(ADDR_CTRL_B, {5'h00, CS_EXT_FALL});
		repeat (2) begin
			pins(1'b0, 1'b0, 1'b1, 4);
			pins(1'b0, 1'b0, 1'b0, 4);
		end
		wr(ADDR_CTRL_B, {5'h00, CS_STOP});
		rd(ADDR_CNT_LO, q); `CHK("ext falls", 8'h05, q)
		cpu.wr16(ADDR_CNT_LO, 16'h0000);
		wr(ADDR_CTRL_B, {5'h00, CS_DIV8});
		repeat (80) @(posedge ref_clk);
		wr(ADDR_CTRL_B, {5'h00, CS_STOP});
		rd(ADDR_CNT_LO, q); `CHK("div8 ticks", 1'b1, q == 8'h0A || q == 8'h0B)
		wr(ADDR_CTRL_A, 8'h01);
		cpu.wr16(ADDR_CNT_LO, 16'h00F0);
		wr(ADDR_CTRL_B, 8'h09);
		repeat (40) @(posedge ref_clk);
		wr(ADDR_CTRL_B, 8'h08);
		cpu.rd16(ADDR_CNT_LO, v); `CHK("clear at top", 16'h001B, v)
		`CHK("top ovf", 1'b1, ovf_irq)
		wr(ADDR_FLAGS, 8'h01);
		`CHK("ovf w1c", 1'b0, ovf_irq)
		wr(ADDR_CTRL_A, 8'h00);
	endtask : t_count

	task automatic t_capture();
		logic [15:0] v;
		cpu.wr16(ADDR_CNT_LO, 16'hABCD);
		wr(ADDR_CTRL_B, 8'h40);
		pins(1'b1, 1'b0, 1'b0, 2);
		`CHK("cap early", 1'b0, cap_irq)
		pins(1'b1, 1'b0, 1'b0, 1);
		`CHK("cap irq", 1'b1, cap_irq)
		cpu.rd16(ADDR_CAP_LO, v); `CHK("cap value", 16'hABCD, v)
		wr(ADDR_FLAGS, 8'h20);
		`CHK("flag w1c", 1'b0, cap_irq)
		cpu.wr16(ADDR_CNT_LO, 16'h5555);
		pins(1'b0, 1'b0, 1'b0, 8);
		`CHK("wrong edge", 1'b0, cap_irq)
		pins(1'b1, 1'b0, 1'b0, 8);
		cpu.rd16(ADDR_CAP_LO, v); `CHK("overwrite", 16'h5555, v)
		cap_ack <= 1'b1;
		@(posedge ref_clk);
		cap_ack <= 1'b0;
		repeat (2) @(posedge ref_clk);
		`CHK("cap ack", 1'b0, cap_irq)
	endtask : t_capture

	task automatic t_filter();
		wr(ADDR_CTRL_B, 8'hC0);
		pins(1'b0, 1'b0, 1'b0, 10);
		wr(ADDR_FLAGS, 8'h20);
		pins(1'b1, 1'b0, 1'b0, 3);
		pins(1'b0, 1'b0, 1'b0, 10);
		`CHK("spike", 1'b0, cap_irq)
		pins(1'b1, 1'b0, 1'b0, 3);
		`CHK("filter delay", 1'b0, cap_irq)
		repeat (3) @(posedge ref_clk);
		`CHK("filter hold", 1'b0, cap_irq)
		@(posedge ref_clk);
		`CHK("filtered", 1'b1, cap_irq)
	endtask : t_filter

	task automatic t_source();
		logic [15:0] v;
		wr(ADDR_CTRL_B, 8'h40);
		wr(ADDR_CMP_CTRL, 8'h04);
		repeat (8) @(posedge ref_clk);
		wr(ADDR_FLAGS, 8'h20);
		pins(1'b0, 1'b0, 1'b0, 4);
		pins(1'b1, 1'b0, 1'b0, 8);
		`CHK("pin ignored", 1'b0, cap_irq)
		cpu.wr16(ADDR_CNT_LO, 16'h0BEE);
		pins(1'b1, 1'b1, 1'b0, 8);
		`CHK("cmp capture", 1'b1, cap_irq)
		cpu.rd16(ADDR_CAP_LO, v); `CHK("cmp value", 16'h0BEE, v)
		wr(ADDR_FLAGS, 8'h20);
		pins(1'b1, 1'b0, 1'b0, 2);
		`CHK("cmp fall", 1'b0, cap_irq)
		wr(ADDR_CMP_CTRL, 8'h00);
		repeat (8) @(posedge ref_clk);
		`CHK("switch capture", 1'b1, cap_irq)
		wr(ADDR_CTRL_B, 8'h00);
		wr(ADDR_FLAGS, 8'h20);
		`CHK("edge flip clear", 1'b0, cap_irq)
	endtask : t_source

	task automatic t_top_mode();
		logic [15:0] v;
		wr(ADDR_CTRL_B, 8'h58);
		cpu.wr16(ADDR_CAP_LO, 16'h0234);
		cpu.rd16(ADDR_CAP_LO, v); `CHK("cap write top", 16'h0234, v)
		pins(1'b0, 1'b0, 1'b0, 4);
		pins(1'b1, 1'b0, 1'b0, 8);
		`CHK("capture off", 1'b0, cap_irq)
	endtask : t_top_mode

	task automatic t_mid_reset();
		logic [7:0]  q;
		logic [15:0] v;
		reset_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		rd(ADDR_CTRL_B, q); `CHK("ctrl_b again", CTRL_RESET, q)
		cpu.rd16(ADDR_CNT_LO, v); `CHK("cnt reset", WORD_RESET, v)
		rd(ADDR_FLAGS, q); `CHK("flags again", 8'h00, q)
	endtask : t_mid_reset

	initial begin
		reset_n = 1'b0;
		ext_pin = 1'b0;
		cap_pin = 1'b0;
		cmp_out = 1'b0;
		cap_ack = 1'b0;
		ovf_ack = 1'b0;
		miscompares = 0;
		compares = 0;
		cycles = 0;
		repeat (12) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		t_reset_map();
		t_latch();
		t_count();
		t_capture();
		t_filter();
		t_source();
		t_top_mode();
		t_mid_reset();
		stop_test();
	end
endmodule : timer16_counter_input_capture_bench

`default_nettype wire
